// *** verilog/crr_pkg.sv ***
// Purpose: Constants shared by the chromaticity readback command block.
// Assumes: Command codes arrive MSB first on the serial command link.
// Notes:   Each coordinate is 10 bits; high bytes carry bits 9..2.
// Summary of operation
// [R1] Command 74h returns white vertical coordinate bits 9..2 as one byte.
// [R2] Command 75h returns packed low bits: red x, red y, green x, green y.
// [R3] Command 76h returns red horizontal coordinate bits 9..2 as one byte.
// [R4] Command 77h returns red vertical coordinate bits 9..2 as one byte.
// [R5] Command 78h returns green horizontal coordinate bits 9..2 as one byte.
// [R6] Command 79h returns green vertical coordinate bits 9..2 as one byte.
// [R7] All readback values are zero after power-on, software and hardware reset.
// [R8] Readbacks answer in normal, idle and sleep states alike.
// [R9] These codes are read-only; written parameters never change stored values.
package crr_pkg;
	localparam int          CMD_W                      = 8;
	localparam int          COORD_W                    = 10;
	// Command codes, which double as the register offsets
	localparam logic [7:0]  read_white_vertical_cmd    = 8'h74;
	localparam logic [7:0]  read_red_green_low_cmd     = 8'h75;
	localparam logic [7:0]  read_red_horizontal_cmd    = 8'h76;
	localparam logic [7:0]  read_red_vertical_cmd      = 8'h77;
	localparam logic [7:0]  read_green_horizontal_cmd  = 8'h78;
	localparam logic [7:0]  read_green_vertical_cmd    = 8'h79;
	// Values after any reset
	localparam logic [9:0]  COORD_RESET                = 10'h000;
	localparam logic [7:0]  PARAM_RESET                = 8'h00;
	// Bit counting on the link
	localparam logic [3:0]  CNT_RESET                  = 4'h0;
	localparam logic [3:0]  LAST_CMD_BIT               = 4'h7;
	localparam logic [3:0]  BITS_PER_BYTE              = 4'h8;
	localparam int          SYNC_STAGES                = 2;
endpackage

// *** verilog/crr_link_sync.sv ***
// Purpose: Bring the serial command link pins into the clk domain.
// Assumes: Link clock is far slower than clk (125 ns against 10 ns).
// Notes:   Edges are found after the synchroniser, so they lag by about two cycles.
`timescale 1ns/1ps
module crr_link_sync #(
	parameter int STAGES = crr_pkg::SYNC_STAGES
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic link_clk,
	input  wire logic link_cs_n,
	input  wire logic link_sdi,
	output logic      clk_rise,
	output logic      clk_fall,
	output logic      cs_n_s,
	output logic      sdi_s
);
	import crr_pkg::*;

	typedef struct packed {
		logic [STAGES-1:0] sclk;
		logic [STAGES-1:0] cs_n;
		logic [STAGES-1:0] sdi;
		logic              sclk_old;
	} crr_sync_t;

	crr_sync_t q_r;
	crr_sync_t q_nxt;

	// Fewer than two stages would let metastability reach the decoder
	if (STAGES < 2) begin : g_bad_stages
		$error("crr_link_sync needs at least two stages");
	end

	// Shift each pin down its chain; only the last stage is looked at
	always_comb begin
		q_nxt          = q_r;
		q_nxt.sclk     = {q_r.sclk[STAGES-2:0], link_clk};
		q_nxt.cs_n     = {q_r.cs_n[STAGES-2:0], link_cs_n};
		q_nxt.sdi      = {q_r.sdi[STAGES-2:0], link_sdi};
		q_nxt.sclk_old = q_r.sclk[STAGES-1];
	end

	// Chip select resets high so the link starts deselected
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_r.sclk     <= '0;
			q_r.cs_n     <= '1;
			q_r.sdi      <= '0;
			q_r.sclk_old <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Edge pulses are one clk cycle wide
	assign clk_rise = q_r.sclk[STAGES-1] & ~q_r.sclk_old;
	assign clk_fall = ~q_r.sclk[STAGES-1] & q_r.sclk_old;
	assign cs_n_s   = q_r.cs_n[STAGES-1];
	assign sdi_s    = q_r.sdi[STAGES-1];
endmodule // crr_link_sync

// *** verilog/crr_regs.sv ***
// Purpose: Read-only chromaticity readback registers behind the command link.
// Assumes: Host samples returned bits on rising link clock, device changes on falling.
// Notes:   Coordinates are loaded by device logic, never by the host.
`timescale 1ns/1ps
module crr_regs (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     sw_reset,
	input  wire logic                     coord_load,
	input  wire logic [crr_pkg::COORD_W-1:0] white_vertical_coord,
	input  wire logic [crr_pkg::COORD_W-1:0] red_horizontal_coord,
	input  wire logic [crr_pkg::COORD_W-1:0] red_vertical_coord,
	input  wire logic [crr_pkg::COORD_W-1:0] green_horizontal_coord,
	input  wire logic [crr_pkg::COORD_W-1:0] green_vertical_coord,
	input  wire logic                     link_clk,
	input  wire logic                     link_cs_n,
	input  wire logic                     link_sdi,
	output logic                          link_sdo,
	output logic                          link_sdo_oe
);
	import crr_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_TURN, ST_SEND, ST_DONE} crr_state_t;

	typedef struct packed {
		crr_state_t         st;
		logic [3:0]         cnt;
		logic [CMD_W-1:0]   cmd_sh;
		logic [CMD_W-1:0]   tx_sh;
		logic               oe;
		logic [COORD_W-1:0] white_v;
		logic [COORD_W-1:0] red_h;
		logic [COORD_W-1:0] red_v;
		logic [COORD_W-1:0] green_h;
		logic [COORD_W-1:0] green_v;
	} crr_regs_t;

	crr_regs_t q_r;
	crr_regs_t q_nxt;
	logic      rise;
	logic      fall;
	logic      cs_n_s;
	logic      sdi_s;

	// True for the six codes this bank answers
	function automatic logic is_read_code(input logic [CMD_W-1:0] c);
		return (c >= read_white_vertical_cmd) && (c <= read_green_vertical_cmd);
	endfunction

	// Parameter byte for a command; unknown codes give zero
	function automatic logic [CMD_W-1:0] param_of(input logic [CMD_W-1:0] c,
	                                              input crr_regs_t s);
		case (c)
			read_white_vertical_cmd:   return s.white_v[9:2]; // R1
			read_red_green_low_cmd:    return {s.red_h[1:0], s.red_v[1:0],
			                                   s.green_h[1:0], s.green_v[1:0]}; // R2
			read_red_horizontal_cmd:   return s.red_h[9:2];   // R3
			read_red_vertical_cmd:     return s.red_v[9:2];   // R4
			read_green_horizontal_cmd: return s.green_h[9:2]; // R5
			read_green_vertical_cmd:   return s.green_v[9:2]; // R6
			default:                   return PARAM_RESET;
		endcase
	endfunction

	crr_link_sync u_sync (
		.clk       (clk),
		.reset     (reset),
		.link_clk  (link_clk),
		.link_cs_n (link_cs_n),
		.link_sdi  (link_sdi),
		.clk_rise  (rise),
		.clk_fall  (fall),
		.cs_n_s    (cs_n_s),
		.sdi_s     (sdi_s)
	);

	// Store update and command sequencing in one next-state block
	always_comb begin
		q_nxt = q_r;
		// Only device logic loads values; link bits never reach the store
		if (coord_load) begin
			q_nxt.white_v = white_vertical_coord;
			q_nxt.red_h   = red_horizontal_coord;
			q_nxt.red_v   = red_vertical_coord;
			q_nxt.green_h = green_horizontal_coord;
			q_nxt.green_v = green_vertical_coord;
		end
		// Software reset wins over a load in the same cycle
		if (sw_reset) begin
			q_nxt.white_v = COORD_RESET; // R7
			q_nxt.red_h   = COORD_RESET; // R7
			q_nxt.red_v   = COORD_RESET; // R7
			q_nxt.green_h = COORD_RESET; // R7
			q_nxt.green_v = COORD_RESET; // R7
		end
		case (q_r.st)
			ST_IDLE: begin
				if (!cs_n_s) begin
					q_nxt.st  = ST_CMD;
					q_nxt.cnt = CNT_RESET;
				end
			end
			ST_CMD: begin
				if (rise) begin
					q_nxt.cmd_sh = {q_r.cmd_sh[CMD_W-2:0], sdi_s};
					q_nxt.cnt    = q_r.cnt + 4'h1;
					if (q_r.cnt == LAST_CMD_BIT) begin
						q_nxt.st = ST_TURN;
					end
				end
			end
			// Wait a falling edge so the first bit is set up for rise nine
			ST_TURN: begin
				if (fall) begin
					// No sleep or idle gating: answers in every power state
					if (is_read_code(q_r.cmd_sh)) begin // R8
						q_nxt.tx_sh = param_of(q_r.cmd_sh, q_r);
						q_nxt.oe    = 1'b1;
						q_nxt.cnt   = CNT_RESET;
						q_nxt.st    = ST_SEND;
					end else begin
						q_nxt.st = ST_DONE;
					end
				end
			end
			ST_SEND: begin
				if (rise) begin
					q_nxt.cnt = q_r.cnt + 4'h1;
				end
				if (fall) begin
					if (q_r.cnt == BITS_PER_BYTE) begin
						q_nxt.oe = 1'b0;
						q_nxt.st = ST_DONE;
					end else begin
						q_nxt.tx_sh = {q_r.tx_sh[CMD_W-2:0], 1'b0};
					end
				end
			end
			// Trailing host bits, such as attempted writes, fall away here
			ST_DONE: begin
				q_nxt.st = ST_DONE; // R9
			end
			default: begin
				q_nxt.st = ST_IDLE;
			end
		endcase
		// Deselect ends any frame at once and frees the data line
		if (cs_n_s) begin
			q_nxt.st = ST_IDLE;
			q_nxt.oe = 1'b0;
		end
	end

	// Hardware reset clears every stored coordinate
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_r.st      <= ST_IDLE;
			q_r.cnt     <= CNT_RESET;
			q_r.cmd_sh  <= PARAM_RESET;
			q_r.tx_sh   <= PARAM_RESET;
			q_r.oe      <= 1'b0;
			q_r.white_v <= COORD_RESET; // R7
			q_r.red_h   <= COORD_RESET; // R7
			q_r.red_v   <= COORD_RESET; // R7
			q_r.green_h <= COORD_RESET; // R7
			q_r.green_v <= COORD_RESET; // R7
		end else begin
			q_r <= q_nxt;
		end
	end

	// Both outputs are plain flop bits
	assign link_sdo    = q_r.tx_sh[CMD_W-1];
	assign link_sdo_oe = q_r.oe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence load_s(logic [7:0] code);
		q_r.st == ST_TURN && fall && !cs_n_s && q_r.cmd_sh == code;
	endsequence

	// Loaded bytes checked against the store at the moment of loading
	white_v_read_a: assert property (load_s(read_white_vertical_cmd) |=> // R1
		q_r.tx_sh == $past(q_r.white_v[9:2]) && link_sdo_oe)
		else $error("white vertical readback wrong");
	low_bits_read_a: assert property (load_s(read_red_green_low_cmd) |=> // R2
		q_r.tx_sh == {$past(q_r.red_h[1:0]), $past(q_r.red_v[1:0]),
		              $past(q_r.green_h[1:0]), $past(q_r.green_v[1:0])})
		else $error("red green low bits readback wrong");
	red_h_read_a: assert property (load_s(read_red_horizontal_cmd) |=> // R3
		link_sdo == $past(q_r.red_h[9]) && q_r.tx_sh == $past(q_r.red_h[9:2]))
		else $error("red horizontal readback wrong");
	red_v_read_a: assert property (load_s(read_red_vertical_cmd) |=> // R4
		q_r.tx_sh == $past(q_r.red_v[9:2]))
		else $error("red vertical readback wrong");
	green_h_read_a: assert property (load_s(read_green_horizontal_cmd) |=> // R5
		q_r.tx_sh == $past(q_r.green_h[9:2]))
		else $error("green horizontal readback wrong");
	green_v_read_a: assert property (load_s(read_green_vertical_cmd) |=> // R6
		q_r.tx_sh == $past(q_r.green_v[9:2]))
		else $error("green vertical readback wrong");
	sw_reset_clear_a: assert property (sw_reset |=> // R7
		{q_r.white_v, q_r.red_h, q_r.red_v, q_r.green_h, q_r.green_v} == '0)
		else $error("software reset left a coordinate set");
	byte_release_a: assert property ((q_r.st == ST_SEND && !cs_n_s) |-> // R8
		link_sdo_oe && q_r.cnt <= BITS_PER_BYTE)
		else $error("data line not driven for whole answer byte");
	store_read_only_a: assert property ((!coord_load && !sw_reset) |=> // R9
		$stable({q_r.white_v, q_r.red_h, q_r.red_v, q_r.green_h, q_r.green_v}))
		else $error("stored coordinate changed without a load");
	deselect_free_a: assert property (cs_n_s |=> !link_sdo_oe) // R8
		else $error("data line driven while deselected");

	white_read_c: cover property (load_s(read_white_vertical_cmd) ##[1:200]
		(q_r.st == ST_DONE));
	low_read_c: cover property (load_s(read_red_green_low_cmd));
	unknown_cmd_c: cover property (q_r.st == ST_TURN && fall
		&& !is_read_code(q_r.cmd_sh));
	sw_reset_c: cover property (sw_reset && coord_load);
endmodule // crr_regs

// *** testbench/crr_host_model.sv ***
// Purpose: Host side of the serial command link, issuing one command per frame.
// Assumes: Mode 0 link: host changes data on falling edges, samples on rising.
// Notes:   Link clock stands still low between frames; 125 ns period inside them.
`timescale 1ns/1ps
module crr_host_model (
	output logic      link_clk,
	output logic      link_cs_n,
	output logic      link_sdi,
	input  wire logic link_sdo,
	input  wire logic link_sdo_oe
);
	localparam realtime HALF = 62.5;

	// Idle link at time zero
	initial begin
		link_clk = 1'b0;
		link_cs_n = 1'b1;
		link_sdi = 1'b0;
	end

	// One frame: command byte, then a parameter byte that is really a write attempt
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] prm,
		output logic [7:0] rd, output logic seen);
		logic [15:0] bits;
		bits = {cmd, prm};
		rd = 8'h00;
		seen = 1'b0;
		link_cs_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			link_sdi = bits[15 - i];
			#(HALF);
			link_clk = 1'b1;
			// Answer bits are taken on rises 9..16, MSB first
			if (i >= 8) begin
				// An undriven line reads as the inverse, so an early release shows up
				rd = {rd[6:0], link_sdo_oe ? link_sdo : ~link_sdo};
				seen = seen | link_sdo_oe;
			end
			#(HALF);
			link_clk = 1'b0;
		end
		#(HALF);
		link_cs_n = 1'b1;
		link_sdi = ~link_sdi;  // No stale level is left on the data line
		#(4 * HALF);
	endtask
endmodule // crr_host_model

// *** testbench/chromaticity_readback_regs_bench.sv ***
// Purpose: Self-checking bench for the chromaticity readback registers.
// Assumes: Host model frames on the link; coordinates loaded through the store port.
// Notes:   Each read carries a random parameter byte, so every frame also tries a write.
`timescale 1ns/1ps
module chromaticity_readback_regs_bench;
	import crr_pkg::*;
	logic               clk        = 1'b0;
	logic               reset      = 1'b1;
	logic               sw_reset   = 1'b0;
	logic               coord_load = 1'b0;
	logic [COORD_W-1:0] cin [0:4]  = '{default: 10'h000};
	logic [COORD_W-1:0] m [0:4]    = '{default: 10'h000};
	logic [7:0]         codes [0:7] = '{read_white_vertical_cmd, read_red_green_low_cmd,
		read_red_horizontal_cmd, read_red_vertical_cmd, read_green_horizontal_cmd,
		read_green_vertical_cmd, 8'h73, 8'h7A};
	logic               link_clk, link_cs_n, link_sdi, link_sdo, link_sdo_oe;
	int                 err_count   = 0;
	int                 check_count = 0;

	always #5 clk = ~clk;

	crr_regs u_crr_regs (.clk(clk), .reset(reset), .sw_reset(sw_reset),
		.coord_load(coord_load), .white_vertical_coord(cin[0]),
		.red_horizontal_coord(cin[1]), .red_vertical_coord(cin[2]),
		.green_horizontal_coord(cin[3]), .green_vertical_coord(cin[4]),
		.link_clk(link_clk), .link_cs_n(link_cs_n), .link_sdi(link_sdi),
		.link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));

	crr_host_model u_crr_host_model (.link_clk(link_clk), .link_cs_n(link_cs_n),
		.link_sdi(link_sdi), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Reference answer built from the model store
	function automatic logic [7:0] exp_byte(input logic [7:0] c);
		case (c)
			read_white_vertical_cmd: exp_byte = m[0][9:2];
			read_red_green_low_cmd: exp_byte = {m[1][1:0], m[2][1:0], m[3][1:0], m[4][1:0]};
			read_red_horizontal_cmd: exp_byte = m[1][9:2];
			read_red_vertical_cmd: exp_byte = m[2][9:2];
			read_green_horizontal_cmd: exp_byte = m[3][9:2];
			default: exp_byte = m[4][9:2];
		endcase
	endfunction

	// All six codes plus two neighbours that must stay silent
	task automatic read_all();
		logic [7:0] rd;
		logic       seen;
		for (int k = 0; k < 8; k++) begin
			// Frames start just after a clk edge, so no link edge lands on one
			@(posedge clk);
			#1;
			u_crr_host_model.xfer(codes[k], 8'($urandom), rd, seen);
			check({7'h00, seen}, {7'h00, k < 6});
			if (k < 6) begin
				check(rd, exp_byte(codes[k]));
			end
		end
	endtask

	// Random coordinates into design and model; optional software reset in the same cycle
	task automatic load(input logic clr);
		@(posedge clk);
		#1;
		for (int i = 0; i < 5; i++) begin
			cin[i] = 10'($urandom);
			m[i] = clr ? 10'h000 : cin[i];
		end
		coord_load = 1'b1;
		sw_reset = clr;
		@(posedge clk);
		#1;
		coord_load = 1'b0;
		sw_reset = 1'b0;
	endtask

	initial begin
		void'($urandom(63));
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		read_all();
		repeat (3) begin
			load(1'b0);
			read_all();
		end
		// Software reset wins over a load in the same cycle
		load(1'b1);
		read_all();
		// Hardware reset in mid-run clears a loaded store
		load(1'b0);
		@(posedge clk);
		#1 reset = 1'b1;
		m = '{default: 10'h000};
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		read_all();
		end_sim();
	end

	// Watchdog against a hung link
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule // chromaticity_readback_regs_bench
